// *** verilog/tpb_pkg.sv ***
// constants and carrier types for the timer pwm and buzzer block
package tpb_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_BZ_COUNT  = 8'h9B;
  localparam logic [7:0] IDX_BZ_MODE   = 8'h9C;
  localparam logic [7:0] IDX_TA_MODE   = 8'hD1;
  localparam logic [7:0] IDX_TA_COUNT  = 8'hD2;
  localparam logic [7:0] IDX_TA_REF    = 8'hD3;
  localparam logic [7:0] IDX_TB_FAST   = 8'hD8;
  localparam logic [7:0] IDX_TB_MODE   = 8'hDC;
  localparam logic [7:0] IDX_TB_COUNT  = 8'hDD;
  localparam logic [7:0] IDX_TB_RELOAD = 8'hDE;
  localparam logic [7:0] IDX_STATUS    = 8'hDF;
  // field positions
  localparam int EN_BIT      = 7;
  localparam int RATE_HI     = 6;
  localparam int RATE_LO     = 4;
  localparam int TB_EXT_BIT  = 3;
  localparam int TB_ALD_BIT  = 2;
  localparam int TB_PWM_BIT  = 1;
  localparam int TB_TONE_BIT = 0;
  localparam int TA_PWM_BIT  = 0;
  localparam int TB_FAST_BIT = 3;
  localparam int BZ_SRC_BIT  = 2;
  localparam int ST_TA_IRQ   = 0;
  localparam int ST_TB_IRQ   = 1;
  localparam int ST_TB_IEN   = 2;
  // writable bits and reset values
  localparam logic [7:0] BZ_MODE_MASK = 8'hF4;
  localparam logic [7:0] TA_MODE_MASK = 8'hF1;
  localparam logic [7:0] FAST_MASK    = 8'h08;
  localparam logic [7:0] REG_RST      = 8'h00;
  localparam logic [7:0] CNT_MAX      = 8'hFF;
  localparam logic [7:0] CNT_ONE      = 8'h01;
  // cpu clock is the oscillator clock divided by four
  localparam logic [1:0] CPU_DIV_LAST = 2'h3;
  localparam logic [3:0] K_ONE        = 4'h1;
  localparam int         ADR_W        = 10;
  localparam logic [31:0] RD_ZERO     = 32'h0000_0000;

  typedef struct packed {
    logic o;
    logic oe;
  } tpb_pin_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [3:0]       sel;
    logic [ADR_W-1:0] adr;
    logic [31:0]      dat;
  } tpb_wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } tpb_wb_rsp_t;

  // a prescaler tap fires when the low k bits of the counter are all ones
  function automatic logic tpb_tap(input logic [7:0] cnt,
                                   input logic [3:0] k);
    logic [7:0] mask;
    mask = ~(8'hFF << k);
    return (cnt & mask) == mask;
  endfunction : tpb_tap
endpackage : tpb_pkg

// *** verilog/tpb_timers.sv ***
// two 8-bit pwm timers, tone output and buzzer timer with wishbone regs
// Summary of operation
// (R1) tone output toggles on each timer b overflow, halving frequency
// (R2) an enabled tone or pwm output takes over its shared port pin
// (R3) software keeps timer b pwm off while using the tone output
// (R4) software stops, reconfigures, then re-enables timer b last
// (R5) clearing timer b enable halts counting, tone and pwm outputs
// (R6) timer b rate field sits in mode bits 6 to 4, 111 fastest
// (R7) with external clock the fast source select has no effect
// (R8) pwm counter wraps modulo 256 and compares with its reference
// (R9) pwm high while count below reference, low otherwise
// (R10) pwm high when the counter wraps through zero, if the reference is nonzero
// (R11) duty equals reference over 256, zero reference gives zero duty
// (R12) timer a pwm goes to its own pin, timer b pwm to shared pin
// (R13) reference registers are write-only and written whole
// (R14) a counter write changes the compare at once
// (R15) software changes duty only at the start of a period
// (R16) overflow flag still sets on each wrap in pwm mode
// (R17) buzzer mode: enable bit 7, rate bits 6-4, source bit 2, reset 0
// (R18) buzzer rates: cpu clock /256 to /2, or oscillator /128 to /1
// (R19) buzzer enable drives buzzer pin, clearing it stops the output
// (R20) buzzer count is 8-bit read/write preload, reset zero
// (R21) timer b reload register feeds reload and the pwm compare
// (R22) timer b overflow with auto-reload copies reload into counter
// (R23) pwm mode wraps to zero without reload, auto-reload bit not used
// (R24) buzzer counter reloads and toggles the buzzer pin on overflow
// (R25) disabled function returns the pin to gpio on the next clock
`timescale 1ns/10ps
`default_nettype none
module tpb_timers
  import tpb_pkg::*;
(
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire tpb_pkg::tpb_wb_req_t wb_req,
  output      tpb_pkg::tpb_wb_rsp_t wb_rsp,
  input  wire logic               ext_clk_pin,
  input  wire tpb_pkg::tpb_pin_t  gpio_a,
  input  wire tpb_pkg::tpb_pin_t  gpio_b,
  output      tpb_pkg::tpb_pin_t  pin_a,
  output      tpb_pkg::tpb_pin_t  pin_b,
  output      logic               buzzer_pin
);
  import tpb_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] ta_mode_q, ta_cnt_q, ta_ref_q;
  logic [7:0] tb_mode_q, tb_cnt_q, tb_rld_q, tb_fast_q;
  logic [7:0] bz_mode_q, bz_cnt_q, bz_ctr_q;
  logic       ta_irq_q, tb_irq_q, tb_ien_q;
  logic       tone_q, pwm_a_q, pwm_b_q, bz_out_q;
  logic       ack_q;
  logic [7:0] rdat_q;
  logic [1:0] cpu_div_q;
  logic [7:0] osc_pre_q, cpu_pre_q;
  logic [2:0] ext_sync_q;
  tpb_pin_t   pin_a_q, pin_b_q;

  ////////////////////////////////////////////////////////////////////
  // wishbone decode
  logic       req, wr;
  logic [7:0] idx, wdat;
  assign req  = wb_req.cyc & wb_req.stb & ~ack_q;
  assign wr   = req & wb_req.we & wb_req.sel[0];
  assign idx  = wb_req.adr[ADR_W-1:2];
  assign wdat = wb_req.dat[7:0];

  logic wr_ta_mode, wr_ta_cnt, wr_ta_ref, wr_tb_mode, wr_tb_cnt;
  logic wr_tb_rld, wr_fast, wr_st, wr_bz_mode, wr_bz_cnt;
  assign wr_ta_mode = wr & (idx == IDX_TA_MODE);
  assign wr_ta_cnt  = wr & (idx == IDX_TA_COUNT);
  assign wr_ta_ref  = wr & (idx == IDX_TA_REF);
  assign wr_tb_mode = wr & (idx == IDX_TB_MODE);
  assign wr_tb_cnt  = wr & (idx == IDX_TB_COUNT);
  assign wr_tb_rld  = wr & (idx == IDX_TB_RELOAD);
  assign wr_fast    = wr & (idx == IDX_TB_FAST);
  assign wr_st      = wr & (idx == IDX_STATUS);
  assign wr_bz_mode = wr & (idx == IDX_BZ_MODE);
  assign wr_bz_cnt  = wr & (idx == IDX_BZ_COUNT);

  // mode fields
  logic ta_en, ta_pwm, tb_en, tb_ext, tb_ald, tb_pwm, tb_tone;
  logic bz_en, bz_src, tb_fast;
  logic [2:0] ta_rate, tb_rate, bz_rate;
  assign ta_en   = ta_mode_q[EN_BIT];
  assign ta_pwm  = ta_mode_q[TA_PWM_BIT];
  assign ta_rate = ta_mode_q[RATE_HI:RATE_LO];
  assign tb_en   = tb_mode_q[EN_BIT];
  assign tb_rate = tb_mode_q[RATE_HI:RATE_LO];        // [R6]
  assign tb_ext  = tb_mode_q[TB_EXT_BIT];
  assign tb_ald  = tb_mode_q[TB_ALD_BIT];
  assign tb_pwm  = tb_mode_q[TB_PWM_BIT];
  assign tb_tone = tb_mode_q[TB_TONE_BIT];
  assign tb_fast = tb_fast_q[TB_FAST_BIT];
  assign bz_en   = bz_mode_q[EN_BIT];                 // [R17]
  assign bz_src  = bz_mode_q[BZ_SRC_BIT];             // [R17]
  assign bz_rate = bz_mode_q[RATE_HI:RATE_LO];        // [R17]

  ////////////////////////////////////////////////////////////////////
  // prescalers: free oscillator chain and a cpu chain on the /4 enable
  logic cpu_en;
  assign cpu_en = (cpu_div_q == CPU_DIV_LAST);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_div_q <= '0;
      osc_pre_q <= REG_RST;
      cpu_pre_q <= REG_RST;
    end else begin
      cpu_div_q <= cpu_div_q + 2'h1;
      osc_pre_q <= osc_pre_q + CNT_ONE;
      if (cpu_en) begin
        cpu_pre_q <= cpu_pre_q + CNT_ONE;
      end
    end
  end

  // cpu rate code r divides by 2^(8-r), oscillator code by 2^(7-r)
  // chains come in as arguments: a continuous assignment only wakes on
  // its operands, so a hidden read would leave the tick stale
  function automatic logic cpu_tick(input logic       en,
                                    input logic [7:0] pre,
                                    input logic [2:0] r);
    return en & tpb_tap(pre, {1'b0, ~r} + K_ONE);
  endfunction : cpu_tick

  function automatic logic osc_tick(input logic [7:0] pre,
                                    input logic [2:0] r);
    return tpb_tap(pre, {1'b0, ~r});
  endfunction : osc_tick

  // external clock: two flops, then edge detect on the settled copies
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ext_sync_q <= '0;
    end else begin
      ext_sync_q <= {ext_sync_q[1:0], ext_clk_pin};
    end
  end
  logic ext_rise;
  assign ext_rise = ext_sync_q[1] & ~ext_sync_q[2];

  ////////////////////////////////////////////////////////////////////
  // timer a: plain modulo-256 up counter on the cpu prescaler
  logic ta_tick, ta_ovf;
  assign ta_tick = ta_en & cpu_tick(cpu_en, cpu_pre_q, ta_rate);
  assign ta_ovf  = ta_tick & ~wr_ta_cnt & (ta_cnt_q == CNT_MAX);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ta_cnt_q <= REG_RST;
    end else if (wr_ta_cnt) begin
      ta_cnt_q <= wdat;                               // [R14]
    end else if (ta_tick) begin
      ta_cnt_q <= ta_cnt_q + CNT_ONE;                 // [R8]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // timer b: rate, fast source or external clock, optional reload
  logic tb_src, tb_tick, tb_ovf;
  // fast select only matters for the internal source
  assign tb_src  = tb_ext ? ext_rise                  // [R7]
                 : (tb_fast ? osc_tick(osc_pre_q, tb_rate)
                            : cpu_tick(cpu_en, cpu_pre_q, tb_rate));
  assign tb_tick = tb_en & tb_src;                    // [R5]
  assign tb_ovf  = tb_tick & ~wr_tb_cnt & (tb_cnt_q == CNT_MAX);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tb_cnt_q <= REG_RST;
    end else if (wr_tb_cnt) begin
      tb_cnt_q <= wdat;                               // [R14]
    end else if (tb_ovf & tb_ald & ~tb_pwm) begin
      tb_cnt_q <= tb_rld_q;                           // [R21] [R22]
    end else if (tb_tick) begin
      // pwm keeps the full 256-step period, so it wraps to zero
      tb_cnt_q <= tb_cnt_q + CNT_ONE;                 // [R8] [R23]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // software registers; references are write-only
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ta_mode_q <= REG_RST;
      ta_ref_q  <= REG_RST;
      tb_mode_q <= REG_RST;
      tb_rld_q  <= REG_RST;
      tb_fast_q <= REG_RST;
      bz_mode_q <= REG_RST;
      bz_cnt_q  <= REG_RST;
    end else begin
      if (wr_ta_mode) ta_mode_q <= wdat & TA_MODE_MASK;
      if (wr_ta_ref)  ta_ref_q  <= wdat;              // [R13]
      if (wr_tb_mode) tb_mode_q <= wdat;
      if (wr_tb_rld)  tb_rld_q  <= wdat;              // [R13]
      if (wr_fast)    tb_fast_q <= wdat & FAST_MASK;
      if (wr_bz_mode) bz_mode_q <= wdat & BZ_MODE_MASK; // [R17]
      if (wr_bz_cnt)  bz_cnt_q  <= wdat;              // [R20]
    end
  end

  // overflow flags: a wrap in the clearing cycle still sets the flag
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ta_irq_q <= 1'b0;
      tb_irq_q <= 1'b0;
      tb_ien_q <= 1'b0;
    end else begin
      ta_irq_q <= (wr_st ? wdat[ST_TA_IRQ] : ta_irq_q) | ta_ovf; // [R16]
      tb_irq_q <= (wr_st ? wdat[ST_TB_IRQ] : tb_irq_q) | tb_ovf; // [R16]
      if (wr_st) tb_ien_q <= wdat[ST_TB_IEN];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // waveforms; the compare reads the live count so writes act at once
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_a_q <= 1'b0;
      pwm_b_q <= 1'b0;
    end else begin
      // count zero after a wrap is below any nonzero reference
      pwm_a_q <= ta_en & ta_pwm & (ta_cnt_q < ta_ref_q); // [R9] [R10] [R11]
      pwm_b_q <= tb_en & tb_pwm & (tb_cnt_q < tb_rld_q); // [R9] [R21] [R5]
    end
  end

  // tone toggles per overflow and parks low when stopped
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tone_q <= 1'b0;
    end else if (~(tb_en & tb_tone)) begin
      tone_q <= 1'b0;                                 // [R5]
    end else if (tb_ovf) begin
      tone_q <= ~tone_q;                              // [R1]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // buzzer timer: counts up from the preload and toggles on overflow
  logic bz_tick, bz_wrap;
  assign bz_tick = bz_en & (bz_src ? osc_tick(osc_pre_q, bz_rate) // [R18]
                                   : cpu_tick(cpu_en, cpu_pre_q, bz_rate));
  assign bz_wrap = bz_tick & (bz_ctr_q == CNT_MAX);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      bz_ctr_q <= REG_RST;
      bz_out_q <= 1'b0;
    end else if (~bz_en) begin
      // held at the preload so the first half period is full length
      bz_ctr_q <= bz_cnt_q;
      bz_out_q <= 1'b0;                               // [R19]
    end else if (bz_wrap) begin
      bz_ctr_q <= bz_cnt_q;                           // [R24]
      bz_out_q <= ~bz_out_q;                          // [R24]
    end else if (bz_tick) begin
      bz_ctr_q <= bz_ctr_q + CNT_ONE;                 // [R20]
    end
  end

  ////////////////////////////////////////////////////////////////////
  // pin muxes, registered so a release lands one clock later
  logic fn_a, fn_b;
  assign fn_a = ta_pwm;                               // [R12]
  assign fn_b = tb_tone | tb_pwm;                     // [R12]
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      pin_a_q <= '0;
      pin_b_q <= '0;
    end else begin
      pin_a_q <= fn_a ? tpb_pin_t'{o: pwm_a_q, oe: 1'b1}    // [R2]
                      : gpio_a;                             // [R25]
      // both sources merge; only one is meant to run at a time
      pin_b_q <= fn_b ? tpb_pin_t'{o: tone_q | pwm_b_q, oe: 1'b1} // [R2] [R3]
                      : gpio_b;                             // [R25]
    end
  end
  assign pin_a      = pin_a_q;
  assign pin_b      = pin_b_q;
  assign buzzer_pin = bz_out_q;                       // [R19]

  ////////////////////////////////////////////////////////////////////
  // bus answer: one wait state, unmapped and write-only read as zero
  logic [7:0] rd_d;
  always_comb begin
    rd_d = REG_RST;
    unique case (idx)
      IDX_TA_MODE:  rd_d = ta_mode_q;
      IDX_TA_COUNT: rd_d = ta_cnt_q;
      IDX_TB_MODE:  rd_d = tb_mode_q;
      IDX_TB_COUNT: rd_d = tb_cnt_q;
      IDX_TB_FAST:  rd_d = tb_fast_q;
      IDX_STATUS:   rd_d = {5'h00, tb_ien_q, tb_irq_q, ta_irq_q};
      IDX_BZ_MODE:  rd_d = bz_mode_q;
      IDX_BZ_COUNT: rd_d = bz_cnt_q;
      default:      rd_d = REG_RST;                   // [R13]
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q  <= 1'b0;
      rdat_q <= REG_RST;
    end else begin
      ack_q  <= req;
      rdat_q <= req ? rd_d : REG_RST;
    end
  end
  assign wb_rsp = '{ack: ack_q, dat: {24'h000000, rdat_q}};

  ////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence ta_wrap_s;
    ta_ovf && ta_en && ta_pwm ##1 ta_en && ta_pwm && ta_ref_q != REG_RST;
  endsequence
  sequence bz_wrap_s;
    bz_wrap ##1 bz_en;
  endsequence

  tone_toggle_a: assert property (                    // [R1]
    tb_ovf && tb_en && tb_tone ##1 tb_en && tb_tone
    |-> tone_q != $past(tone_q))
    else $error("tone did not toggle on overflow");
  pin_takeover_a: assert property (                   // [R2]
    fn_b |=> pin_b_q.oe)
    else $error("shared pin not taken by waveform");
  stop_outputs_a: assert property (                   // [R5]
    !tb_en |=> !tone_q && !pwm_b_q && $stable(tb_cnt_q) || $past(wr_tb_cnt))
    else $error("timer b output alive while disabled");
  ext_source_a: assert property (                     // [R7]
    tb_en && tb_ext && !ext_rise && !wr_tb_cnt |=> $stable(tb_cnt_q))
    else $error("timer b counted without external edge");
  wrap_high_a: assert property (                      // [R10]
    ta_wrap_s |=> pwm_a_q)
    else $error("pwm not high after wrap");
  zero_duty_a: assert property (                      // [R11]
    ta_ref_q == REG_RST |=> !pwm_a_q)
    else $error("pwm high with zero reference");
  flag_set_a: assert property (                       // [R16]
    tb_ovf ##1 !(wr_st && !wdat[ST_TB_IRQ]) |-> tb_irq_q ##1 tb_irq_q)
    else $error("overflow flag missed");
  reload_copy_a: assert property (                    // [R22]
    tb_ovf && tb_ald && !tb_pwm |=> tb_cnt_q == $past(tb_rld_q))
    else $error("auto reload did not load counter");
  buzzer_wrap_a: assert property (                    // [R24]
    bz_wrap_s |-> bz_ctr_q == $past(bz_cnt_q)
                  && bz_out_q != $past(bz_out_q))
    else $error("buzzer did not reload and toggle");
  buzzer_off_a: assert property (                     // [R19]
    !bz_en |=> !buzzer_pin)
    else $error("buzzer driven while disabled");
  pin_release_a: assert property (                    // [R25]
    !fn_b |=> pin_b_q == $past(gpio_b))
    else $error("pin not returned to gpio");
  // compare and routing checks look at the flops one edge after the cause
  pwm_low_a: assert property (                        // [R9]
    ta_en && ta_pwm && ta_cnt_q >= ta_ref_q |=> !pwm_a_q)
    else $error("pwm high at or above reference");
  pwm_b_cmp_a: assert property (                      // [R21]
    tb_en && tb_pwm |=> pwm_b_q == $past(tb_cnt_q < tb_rld_q))
    else $error("timer b pwm compare wrong");
  pwm_wrap_a: assert property (                       // [R23]
    tb_ovf && tb_pwm |=> tb_cnt_q == REG_RST)
    else $error("timer b pwm did not wrap to zero");
  pin_a_route_a: assert property (                    // [R12]
    fn_a |=> pin_a_q.oe && pin_a_q.o == $past(pwm_a_q))
    else $error("timer a pwm not on its pin");
  count_write_a: assert property (                    // [R14]
    wr_ta_cnt |=> ta_cnt_q == $past(wdat))
    else $error("counter write did not land");
  ack_pulse_a: assert property (
    ack_q |=> !ack_q)
    else $error("ack longer than one cycle");
endmodule : tpb_timers
`default_nettype wire

// *** test/timer_pwm_buzzer_outputs_test.sv ***
// self-checking bench for the timer pwm, tone and buzzer block
`timescale 1ns/10ps
`default_nettype none
module timer_pwm_buzzer_outputs_test;
  import tpb_pkg::*;
  logic        clock;
  logic        sys_rst;
  tpb_wb_req_t wb_req;
  tpb_wb_rsp_t wb_rsp;
  logic        ext_clk_pin;
  tpb_pin_t    gpio_a;
  tpb_pin_t    gpio_b;
  tpb_pin_t    pin_a;
  tpb_pin_t    pin_b;
  logic        buzzer_pin;
  int          n_fail;
  int          cmp_count;
  logic [31:0] q;
  int          hi;
  int          ed;
  logic        prev;

  tpb_timers u_dut (
    .clock       (clock),
    .sys_rst     (sys_rst),
    .wb_req      (wb_req),
    .wb_rsp      (wb_rsp),
    .ext_clk_pin (ext_clk_pin),
    .gpio_a      (gpio_a),
    .gpio_b      (gpio_b),
    .pin_a       (pin_a),
    .pin_b       (pin_b),
    .buzzer_pin  (buzzer_pin)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 50 mhz clock
  always #10 clock = ~clock;

  task automatic close_out;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; held until ack is sampled high, one wait state
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] d, output logic [31:0] r);
    int k;
    k = 0;
    @(posedge clock);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1,
                adr: {idx, 2'b00}, dat: {24'h000000, d}};
    do begin
      @(posedge clock);
      k++;
    end while (wb_rsp.ack !== 1'b1);
    r = wb_rsp.dat;
    chk(32'(k), 32'h2);
    wb_req <= '0;
  endtask : xfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] r;
    xfer(1'b1, idx, d, r);
  endtask : wr

  function automatic logic sig(input int sel);
    case (sel)
      0: return pin_a.o;
      1: return pin_b.o;
      default: return buzzer_pin;
    endcase
  endfunction : sig

  // high cycles and toggles of one output over n clocks
  task automatic meas(input int sel, input int n, output int h,
                      output int e);
    logic p;
    logic c;
    h = 0;
    e = 0;
    p = sig(sel);
    repeat (n) begin
      @(posedge clock);
      c = sig(sel);
      h += int'(c === 1'b1);
      e += int'(c !== p);
      p = c;
    end
  endtask : meas

  // timer b stopped first, then set up, enabled last
  task automatic tone_run(input logic fast, input logic [2:0] rate,
                          input int exp);
    int h;
    int e;
    wr(IDX_TB_MODE, 8'h00);
    wr(IDX_TB_FAST, {4'h0, fast, 3'h0});
    wr(IDX_TB_COUNT, 8'hFC);
    wr(IDX_TB_RELOAD, 8'hFC);
    wr(IDX_TB_MODE, {1'b1, rate, 4'h5});
    repeat (40) @(posedge clock);
    meas(1, 256, h, e);
    chk(32'(e), 32'(exp));
    chk({31'h0, pin_b.oe}, 32'h1);
  endtask : tone_run

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, the tests need about eleven thousand clocks
  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    close_out();
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    sys_rst = 1'b1;
    wb_req = '0;
    ext_clk_pin = 1'b0;
    gpio_a = '{o: 1'b1, oe: 1'b0};
    gpio_b = '{o: 1'b0, oe: 1'b1};
    n_fail = 0;
    cmp_count = 0;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    // reset values, masks and write-only places
    xfer(1'b0, IDX_BZ_COUNT, 8'h00, q); chk(q, 32'h0);
    xfer(1'b0, IDX_BZ_MODE, 8'h00, q); chk(q, 32'h0);
    wr(IDX_BZ_MODE, 8'hFF);
    xfer(1'b0, IDX_BZ_MODE, 8'h00, q); chk(q, 32'hF4);
    wr(IDX_BZ_MODE, 8'h00);
    wr(IDX_BZ_COUNT, 8'hA5);
    xfer(1'b0, IDX_BZ_COUNT, 8'h00, q); chk(q, 32'hA5);
    wr(IDX_TA_REF, 8'h5A);
    xfer(1'b0, IDX_TA_REF, 8'h00, q); chk(q, 32'h0);
    xfer(1'b0, 8'h10, 8'h00, q); chk(q, 32'h0);
    chk({30'h0, pin_a}, {30'h0, gpio_a});
    // pwm duty is ref/256; cpu code 7 ticks every 8 clocks
    wr(IDX_TA_COUNT, 8'h00);
    wr(IDX_TA_MODE, 8'hF1);
    for (int i = 0; i < 4; i++) begin
      logic [7:0] rv;
      rv = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : (i == 2) ? 8'h80 : 8'hFF;
      wr(IDX_TA_REF, rv);
      repeat (4) @(posedge clock);
      meas(0, 2048, hi, ed);
      chk(32'(hi), 32'(rv) * 8);
      chk({31'h0, pin_a.oe}, 32'h1);
    end
    // a counter write moves the compare at once
    wr(IDX_TA_REF, 8'h80);
    wr(IDX_TA_COUNT, 8'hC0);
    repeat (3) @(posedge clock);
    chk({31'h0, pin_a.o}, 32'h0);
    wr(IDX_TA_COUNT, 8'h10);
    repeat (3) @(posedge clock);
    chk({31'h0, pin_a.o}, 32'h1);
    xfer(1'b0, IDX_STATUS, 8'h00, q); chk(q & 32'h1, 32'h1);
    wr(IDX_TA_MODE, 8'h00);
    repeat (3) @(posedge clock);
    chk({30'h0, pin_a}, {30'h0, gpio_a});
    // tone: toggles per overflow, four ticks per overflow
    wr(IDX_STATUS, 8'h00);
    tone_run(1'b1, 3'h7, 64);
    tone_run(1'b1, 3'h6, 32);
    tone_run(1'b0, 3'h7, 8);
    xfer(1'b0, IDX_STATUS, 8'h00, q); chk(q & 32'h2, 32'h2);
    wr(IDX_TB_MODE, 8'h75);
    repeat (4) @(posedge clock);
    meas(1, 64, hi, ed);
    chk(32'(ed), 32'h0);
    // external clock: fast select ignored, four edges per overflow
    wr(IDX_TB_FAST, 8'h08);
    wr(IDX_TB_COUNT, 8'hFC);
    // fastest rate: an honoured fast select would count every clock
    wr(IDX_TB_MODE, 8'hFD);
    meas(1, 64, hi, ed);
    chk(32'(ed), 32'h0);
    xfer(1'b0, IDX_TB_COUNT, 8'h00, q); chk(q, 32'hFC);
    prev = pin_b.o;
    repeat (4) begin
      @(posedge clock) ext_clk_pin <= 1'b1;
      repeat (4) @(posedge clock);
      ext_clk_pin <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (6) @(posedge clock);
    chk({31'h0, pin_b.o}, {31'h0, ~prev});
    wr(IDX_TB_MODE, 8'h00);
    repeat (3) @(posedge clock);
    chk({30'h0, pin_b}, {30'h0, gpio_b});
    // timer b pwm: reload is the reference, reload bit must not shorten it
    wr(IDX_TB_RELOAD, 8'h40);
    wr(IDX_TB_MODE, 8'hF6);
    repeat (4) @(posedge clock);
    meas(1, 256, hi, ed);
    chk(32'(hi), 32'h40);
    chk({31'h0, pin_b.oe}, 32'h1);
    wr(IDX_TB_MODE, 8'h00);
    // buzzer: preload FE gives two ticks between toggles
    for (int i = 0; i < 4; i++) begin
      logic       src;
      logic [2:0] r;
      int         per;
      src = (i < 2);
      r = (i == 1 || i == 3) ? 3'h5 : 3'h7;
      if (i == 3) r = 3'h6;
      per = src ? (1 << (7 - r)) : (4 << (8 - r));
      wr(IDX_BZ_MODE, 8'h00);
      wr(IDX_BZ_COUNT, 8'hFE);
      wr(IDX_BZ_MODE, {1'b1, r, 1'b0, src, 2'h0});
      repeat (40) @(posedge clock);
      meas(2, 256, hi, ed);
      chk(32'(ed), 32'(256 / (2 * per)));
    end
    wr(IDX_BZ_MODE, 8'h00);
    repeat (3) @(posedge clock);
    chk({31'h0, buzzer_pin}, 32'h0);
    close_out();
  end
endmodule : timer_pwm_buzzer_outputs_test
`default_nettype wire
